// file: adcs_pkg.sv
// Package of constants and types, plus the conversion clock divider
package adcs_pkg;

	// ------------------------------------------------------------
	// Register map (byte offsets on the plain register port)
	// ------------------------------------------------------------
	localparam logic [2:0] ADCS_OFF_CTRL_A  = 3'h0;
	localparam logic [2:0] ADCS_OFF_CTRL_B  = 3'h1;
	localparam logic [2:0] ADCS_OFF_CTRL_C  = 3'h2;
	localparam logic [2:0] ADCS_OFF_IRQ     = 3'h3;
	localparam logic [2:0] ADCS_OFF_RES_HI  = 3'h4;
	localparam logic [2:0] ADCS_OFF_RES_LO  = 3'h5;

	// conv_ctrl_a fields
	localparam int ADCS_A_CHAN_LSB  = 0;
	localparam int ADCS_A_POWER_BIT = 5;
	localparam int ADCS_A_BUSY_BIT  = 6;
	localparam int ADCS_A_START_BIT = 7;
	// conv_ctrl_b fields
	localparam int ADCS_B_DIV_LSB   = 0;
	localparam int ADCS_B_REFS_BIT  = 3;
	localparam int ADCS_B_TEMP_BIT  = 4;
	localparam int ADCS_B_FMT_BIT   = 7;
	// conv_ctrl_c fields
	localparam int ADCS_C_VSRC_BIT  = 0;
	localparam int ADCS_C_GAIN_BIT  = 1;
	localparam int ADCS_C_DESEL_BIT = 2;
	// irq register fields
	localparam int ADCS_I_GIE_BIT   = 0;
	localparam int ADCS_I_IE_BIT    = 1;
	localparam int ADCS_I_FLAG_BIT  = 2;

	// Reset values
	localparam logic [7:0] ADCS_RST_CTRL_A = 8'h00;
	localparam logic [7:0] ADCS_RST_CTRL_B = 8'h00;
	localparam logic [7:0] ADCS_RST_CTRL_C = 8'h04;

	// ------------------------------------------------------------
	// Conversion timing in conversion clock cycles
	// ------------------------------------------------------------
	localparam logic [5:0] ADCS_SAMPLE_EXT  = 6'h04;
	localparam logic [5:0] ADCS_CONV_BITS   = 6'h0C;
	localparam logic [5:0] ADCS_TEMP_TOTAL  = 6'h38;
	localparam logic [5:0] ADCS_SAMPLE_TEMP = 6'(ADCS_TEMP_TOTAL
		- ADCS_CONV_BITS);
	localparam int         ADCS_RES_W       = 12;
	localparam logic [3:0] ADCS_MSB_IDX     = 4'hB;

	// Reference source codes on the analog side
	localparam logic [1:0] ADCS_REF_SUPPLY = 2'h0;
	localparam logic [1:0] ADCS_REF_PIN    = 2'h1;
	localparam logic [1:0] ADCS_REF_SENSOR = 2'h2;

	// Divider width: largest ratio is 128
	localparam int ADCS_DIV_W = 7;

	typedef enum logic [1:0]
	{
		ADCS_IDLE   = 2'b00,
		ADCS_HOLD   = 2'b01,
		ADCS_SAMPLE = 2'b10,
		ADCS_CONV   = 2'b11
	} adcs_state_t;

endpackage

`timescale 1ns/1ps

// ----------------------------------------------------------------
// Conversion clock divider: one tick every 2**sel system clocks
// ----------------------------------------------------------------
module adcs_clk_div
	import adcs_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_resetn,
	input  wire logic       i_run,
	input  wire logic [2:0] i_sel,
	output logic            o_tick
);

	logic [ADCS_DIV_W-1:0] count;
	wire  [ADCS_DIV_W-1:0] mask = ADCS_DIV_W'((8'h01 << i_sel) - 8'h01);
	wire                   wrap = ((count & mask) == mask);

	// Counter restarts whenever not running so ticks align to the start
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			count  <= '0;
			o_tick <= 1'b0;
		end
		else
		begin
			count  <= (i_run && !wrap) ? count + 1'b1 : '0;
			o_tick <= i_run && wrap;
		end
	end

endmodule

// file: adcs_sequencer.sv
// Conversion sequencer and register file of the 12-bit SAR converter
//
// Overview of operation
// R1 - Conversion clock is system clock divided per conv_clock_div_sel.
// R2 - Converter powered only while conv_power_en is one.
// R3 - temp_sensor_sel low routes external channel input_channel_sel[2:0].
// R4 - temp_sensor_sel high with channel 1xxx routes temperature sensor.
// R5 - Reference chosen from sensor source, gain and ref_select bits.
// R6 - result_format_sel arranges 12-bit result over high and low bytes.
// R7 - Interrupt reaches processor only with global and local enables.
// R8 - Software starts a conversion by pulsing start high then low.
// R9 - Converter held in reset while start high; runs when it falls.
// R10 - Busy flag high during conversion, cleared on completion.
// R11 - After busy falls result registers hold the new result.
// R12 - In auto-conversion mode software must use the interrupt.
// R13 - Power bit cleared switches all converter circuits off.
// R14 - Result is 12-bit unsigned, full scale FFF, step ref/4096.
// R15 - Code transitions sit half a step low, top code 1.5 below.
// R16 - Software clears the flag after start, before enabling irqs.
// R17 - Writing 03H to ctrl_b picks divide-by-8 and supply reference.
// R18 - Writing 20H to ctrl_a powers converter on channel zero.
// R19 - External: 4 sample plus 12 convert clocks; sensor 56 total.
// R20 - Software waits a start-up delay after power enable.
// R21 - Flag sets as busy falls and stays until software clears.
// R22 - New start aborts running conversion; results kept until done.

`timescale 1ns/1ps

module adcs_sequencer
	import adcs_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_resetn,
	input  wire logic [2:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic        i_sar_cmp,
	output logic      [7:0]  o_rdata,
	output logic             o_power_en,
	output logic             o_conv_reset,
	output logic             o_sample,
	output logic      [2:0]  o_ain_sel,
	output logic             o_temp_route,
	output logic      [1:0]  o_ref_src,
	output logic             o_sensor_vsrc,
	output logic             o_ref_gain,
	output logic             o_half_lsb_offset,
	output logic      [11:0] o_dac_code,
	output logic             o_irq
);

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	logic [3:0]            input_channel_sel;
	logic                  conv_power_en;
	logic                  start;
	logic [2:0]            conv_clock_div_sel;
	logic                  ref_select;
	logic                  temp_sensor_sel;
	logic                  result_format_sel;
	logic                  sensor_ref_source_sel;
	logic                  ref_gain_sel;
	logic                  sensor_ref_deselect;
	logic                  global_irq_en;
	logic                  conv_irq_en;
	logic                  conv_irq_flag;
	logic [ADCS_RES_W-1:0] result;
	logic [ADCS_RES_W-1:0] sar;
	logic [3:0]            bit_idx;
	logic [5:0]            phase_cnt;
	adcs_state_t           state;
	adcs_state_t           next_state;
	logic                  tick;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
		hit = (a == o);
	endfunction

	wire wr_a   = i_wr && hit(i_addr, ADCS_OFF_CTRL_A);
	wire wr_b   = i_wr && hit(i_addr, ADCS_OFF_CTRL_B);
	wire wr_c   = i_wr && hit(i_addr, ADCS_OFF_CTRL_C);
	wire wr_irq = i_wr && hit(i_addr, ADCS_OFF_IRQ);

	// Busy covers sampling and converting, not the held-in-reset phase
	wire conv_busy_flag = (state == ADCS_SAMPLE) || (state == ADCS_CONV);
	wire temp_conv      = temp_sensor_sel && input_channel_sel[3];
	wire [5:0] sample_last = 6'((temp_conv ? ADCS_SAMPLE_TEMP
		: ADCS_SAMPLE_EXT) - 6'h01);
	wire sample_done = (state == ADCS_SAMPLE) && tick
		&& (phase_cnt == sample_last);                      // [R19]
	wire conv_done   = (state == ADCS_CONV) && tick
		&& (bit_idx == 4'h0);                               // [R19]
	wire [ADCS_RES_W-1:0] trial_bit = ADCS_RES_W'(12'h001 << bit_idx);
	// Keep the trial bit when the comparator says input is at or above it
	wire [ADCS_RES_W-1:0] sar_kept  = i_sar_cmp ? sar
		: (sar & ~trial_bit);                               // [R14]
	// Next trial code. The DAC port loads it on the same edge as sar, so
	// a tick every clock never judges against a stale trial code
	wire [ADCS_RES_W-1:0] next_sar =
		(state != ADCS_SAMPLE && state != ADCS_CONV) ? '0 :
		sample_done ? ADCS_RES_W'(12'h001 << ADCS_MSB_IDX) :
		(state == ADCS_CONV && tick && !conv_done)
			? (sar_kept | ADCS_RES_W'(12'h001 << (bit_idx - 4'h1)))
		: sar;                                              // [R14]

	// Result placement over the two bytes
	wire [7:0] res_hi = result_format_sel ? {4'h0, result[11:8]}
		: result[11:4];                                     // [R6]
	wire [7:0] res_lo = result_format_sel ? result[7:0]
		: {result[3:0], 4'h0};                              // [R6]

	wire [7:0] ctrl_a_rd = {start, conv_busy_flag, conv_power_en,
		1'b0, input_channel_sel};                           // [R10]
	wire [7:0] ctrl_b_rd = {result_format_sel, 2'h0, temp_sensor_sel,
		ref_select, conv_clock_div_sel};
	wire [7:0] ctrl_c_rd = {5'h00, sensor_ref_deselect, ref_gain_sel,
		sensor_ref_source_sel};
	wire [7:0] irq_rd    = {5'h00, conv_irq_flag, conv_irq_en,
		global_irq_en};

	wire [7:0] rd_mux =
		hit(i_addr, ADCS_OFF_CTRL_A) ? ctrl_a_rd :
		hit(i_addr, ADCS_OFF_CTRL_B) ? ctrl_b_rd :
		hit(i_addr, ADCS_OFF_CTRL_C) ? ctrl_c_rd :
		hit(i_addr, ADCS_OFF_IRQ)    ? irq_rd :
		hit(i_addr, ADCS_OFF_RES_HI) ? res_hi :
		hit(i_addr, ADCS_OFF_RES_LO) ? res_lo : 8'h00;     // [R11]

	// Reference source selection
	wire [1:0] ref_next = ref_select ? ADCS_REF_PIN :
		(!sensor_ref_deselect ? ADCS_REF_SENSOR
		: ADCS_REF_SUPPLY);                                 // [R5]

	// ------------------------------------------------------------
	// Conversion clock divider
	// ------------------------------------------------------------
	adcs_clk_div u_div
	(
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_run     (conv_power_en && conv_busy_flag),      // [R1]
		.i_sel     (conv_clock_div_sel),
		.o_tick    (tick)
	);

	// ------------------------------------------------------------
	// Sequencer state machine
	// ------------------------------------------------------------
	// Start high wins unless power is off, so a restart aborts a running conversion
	always_comb
	begin
		next_state = state;
		unique case (state)
			ADCS_IDLE:   next_state = start ? ADCS_HOLD : ADCS_IDLE;
			ADCS_HOLD:   next_state = start ? ADCS_HOLD : ADCS_SAMPLE;
			ADCS_SAMPLE: next_state = start ? ADCS_HOLD
				: (sample_done ? ADCS_CONV : ADCS_SAMPLE);
			ADCS_CONV:   next_state = start ? ADCS_HOLD
				: (conv_done ? ADCS_IDLE : ADCS_CONV);
		endcase
		if (!conv_power_en)
			next_state = ADCS_IDLE;                         // [R13]
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
			state <= ADCS_IDLE;
		else
			state <= next_state;                            // [R9] [R22]
	end

	// Sample phase counter and successive approximation register
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			phase_cnt <= '0;
			bit_idx   <= ADCS_MSB_IDX;
			sar       <= '0;
		end
		else if (state != ADCS_SAMPLE && state != ADCS_CONV)
		begin
			phase_cnt <= '0;
			bit_idx   <= ADCS_MSB_IDX;
			sar       <= '0;
		end
		else if (sample_done)
		begin
			phase_cnt <= '0;
			sar       <= ADCS_RES_W'(12'h001 << ADCS_MSB_IDX);
		end
		else if (state == ADCS_SAMPLE && tick)
			phase_cnt <= phase_cnt + 6'h01;                 // [R19]
		else if (state == ADCS_CONV && tick && !conv_done)
		begin
			bit_idx <= bit_idx - 4'h1;
			sar     <= sar_kept | ADCS_RES_W'(12'h001 << (bit_idx - 4'h1));
		end
	end

	// Result only changes on a completed conversion
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
			result <= '0;
		else if (conv_done && !start && conv_power_en)
			result <= sar_kept;                             // [R11] [R22]
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			input_channel_sel <= ADCS_RST_CTRL_A[3:0];
			conv_power_en     <= ADCS_RST_CTRL_A[ADCS_A_POWER_BIT];
			start             <= ADCS_RST_CTRL_A[ADCS_A_START_BIT];
		end
		else if (wr_a)
		begin
			input_channel_sel <= i_wdata[ADCS_A_CHAN_LSB +: 4]; // [R18]
			conv_power_en     <= i_wdata[ADCS_A_POWER_BIT];     // [R2]
			start             <= i_wdata[ADCS_A_START_BIT];     // [R9]
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			conv_clock_div_sel <= ADCS_RST_CTRL_B[2:0];
			ref_select         <= ADCS_RST_CTRL_B[ADCS_B_REFS_BIT];
			temp_sensor_sel    <= ADCS_RST_CTRL_B[ADCS_B_TEMP_BIT];
			result_format_sel  <= ADCS_RST_CTRL_B[ADCS_B_FMT_BIT];
		end
		else if (wr_b)
		begin
			conv_clock_div_sel <= i_wdata[ADCS_B_DIV_LSB +: 3]; // [R17]
			ref_select         <= i_wdata[ADCS_B_REFS_BIT];
			temp_sensor_sel    <= i_wdata[ADCS_B_TEMP_BIT];
			result_format_sel  <= i_wdata[ADCS_B_FMT_BIT];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sensor_ref_source_sel <= ADCS_RST_CTRL_C[ADCS_C_VSRC_BIT];
			ref_gain_sel          <= ADCS_RST_CTRL_C[ADCS_C_GAIN_BIT];
			sensor_ref_deselect   <= ADCS_RST_CTRL_C[ADCS_C_DESEL_BIT];
		end
		else if (wr_c)
		begin
			sensor_ref_source_sel <= i_wdata[ADCS_C_VSRC_BIT];
			ref_gain_sel          <= i_wdata[ADCS_C_GAIN_BIT];
			sensor_ref_deselect   <= i_wdata[ADCS_C_DESEL_BIT];
		end
	end

	// Completion sets the flag; a set in the clearing cycle wins
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			global_irq_en <= 1'b0;
			conv_irq_en   <= 1'b0;
			conv_irq_flag <= 1'b0;
		end
		else
		begin
			if (wr_irq)
			begin
				global_irq_en <= i_wdata[ADCS_I_GIE_BIT];
				conv_irq_en   <= i_wdata[ADCS_I_IE_BIT];
			end
			if (conv_done && !start && conv_power_en)
				conv_irq_flag <= 1'b1;                      // [R21]
			else if (wr_irq)
				conv_irq_flag <= i_wdata[ADCS_I_FLAG_BIT];
		end
	end

	// ------------------------------------------------------------
	// Outputs, all registered
	// ------------------------------------------------------------
	// Analog controls except o_sample and o_dac_code follow the registers one cycle late, which is
	// harmless next to the microsecond settling of the analog side
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_rdata           <= 8'h00;
			o_power_en        <= 1'b0;
			o_conv_reset      <= 1'b1;
			o_sample          <= 1'b0;
			o_ain_sel         <= 3'h0;
			o_temp_route      <= 1'b0;
			o_ref_src         <= ADCS_REF_SUPPLY;
			o_sensor_vsrc     <= 1'b0;
			o_ref_gain        <= 1'b0;
			o_half_lsb_offset <= 1'b0;
			o_dac_code        <= '0;
			o_irq             <= 1'b0;
		end
		else
		begin
			o_rdata           <= i_rd ? rd_mux : 8'h00;
			o_power_en        <= conv_power_en;              // [R2] [R13]
			o_conv_reset      <= start || !conv_power_en;    // [R9]
			o_sample          <= (next_state == ADCS_SAMPLE);
			o_ain_sel         <= input_channel_sel[2:0];     // [R3]
			o_temp_route      <= temp_conv;                  // [R4]
			o_ref_src         <= ref_next;                   // [R5]
			o_sensor_vsrc     <= sensor_ref_source_sel;      // [R5]
			o_ref_gain        <= ref_gain_sel;               // [R5]
			o_half_lsb_offset <= conv_power_en;              // [R15]
			o_dac_code        <= next_sar;                   // [R14]
			o_irq             <= conv_irq_flag && conv_irq_en
				&& global_irq_en;                            // [R7]
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_finish;
		conv_done && !start && conv_power_en;
	endsequence

	sequence s_flag_seen;
		##1 conv_irq_flag && !conv_busy_flag;
	endsequence

	property p_flag_on_done;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		s_finish |-> s_flag_seen;
	endproperty
	a_flag_on_done: assert property (p_flag_on_done) // [R21] [R10]
		else $error("flag not set as busy fell");

	property p_irq_gate;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		o_irq |-> $past(global_irq_en && conv_irq_en && conv_irq_flag);
	endproperty
	a_irq_gate: assert property (p_irq_gate) // [R7]
		else $error("interrupt without both enables");

	property p_hold_in_reset;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(start && conv_power_en) |=> (state == ADCS_HOLD) && o_conv_reset;
	endproperty
	a_hold_in_reset: assert property (p_hold_in_reset) // [R9] [R22]
		else $error("converter not held while start high");

	property p_power_off;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		!conv_power_en |=> !o_power_en && !conv_busy_flag;
	endproperty
	a_power_off: assert property (p_power_off) // [R2] [R13]
		else $error("converter active while power bit low");

	property p_result_kept;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		!(conv_done && !start && conv_power_en) |=> $stable(result);
	endproperty
	a_result_kept: assert property (p_result_kept) // [R22] [R11]
		else $error("result changed without completion");

	property p_sample_len;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		sample_done |-> phase_cnt == (temp_conv ? 6'h2B : 6'h03);
	endproperty
	a_sample_len: assert property (p_sample_len) // [R19]
		else $error("wrong sampling length");

	property p_ext_route;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		!temp_sensor_sel |=> !o_temp_route
			&& o_ain_sel == $past(input_channel_sel[2:0]);
	endproperty
	a_ext_route: assert property (p_ext_route) // [R3] [R4]
		else $error("external channel not routed");

	property p_fast_clock;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(conv_clock_div_sel == 3'h0 && conv_busy_flag)[*2] |-> tick;
	endproperty
	a_fast_clock: assert property (p_fast_clock) // [R1]
		else $error("undivided conversion clock missing");

	property p_write_b;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(wr_b && i_wdata == 8'h03) |=> conv_clock_div_sel == 3'h3
			&& !ref_select;
	endproperty
	a_write_b: assert property (p_write_b) // [R17]
		else $error("03H to ctrl_b mis-decoded");

	property p_write_a;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(wr_a && i_wdata == 8'h20) |=> ##1 o_power_en && o_ain_sel == 3'h0
			&& !o_temp_route;
	endproperty
	a_write_a: assert property (p_write_a) // [R18]
		else $error("20H to ctrl_a mis-decoded");

	property p_format;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(i_rd && hit(i_addr, ADCS_OFF_RES_HI) && result_format_sel)
			|=> o_rdata == {4'h0, $past(result[11:8])};
	endproperty
	a_format: assert property (p_format) // [R6]
		else $error("right-aligned high byte wrong");

endmodule

// file: adcs_analog_model.sv
// Analog side model: converter input selection and comparator
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Comparator against the selected analog level
// ----------------------------------------------------------------
module adcs_analog_model
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_power_en,
	input  wire logic [2:0]  i_ain_sel,
	input  wire logic        i_temp_route,
	input  wire logic [11:0] i_dac_code,
	input  wire logic [11:0] i_ext_val,
	input  wire logic [11:0] i_temp_val,
	output logic             o_cmp
);
	logic [11:0] level;
	logic        junk = 1'b0;

	// Channel number folded into top bits so a wrong route shows up
	assign level = i_temp_route ? i_temp_val
		: (i_ext_val ^ {i_ain_sel, 9'h000});
	// Unpowered comparator gives noise, never a stale decision
	always_ff @(posedge i_clk_sys)
		junk <= ~junk;
	assign o_cmp = i_power_en ? (level >= i_dac_code) : junk;
endmodule

// file: adcs_sequencer_tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module adcs_sequencer_tb
	import adcs_pkg::*;
;
	localparam int LIMIT   = 20000;
	localparam int STARTUP = 20;
	logic        i_clk_sys = 1'b0;
	logic        i_resetn  = 1'b0;
	logic [2:0]  i_addr    = 3'h0;
	logic [7:0]  i_wdata   = 8'h00;
	logic        i_wr      = 1'b0;
	logic        i_rd      = 1'b0;
	logic        i_sar_cmp;
	logic [7:0]  o_rdata;
	logic        o_power_en;
	logic        o_conv_reset;
	logic        o_temp_route;
	logic        o_sensor_vsrc;
	logic        o_ref_gain;
	logic        o_irq;
	logic        o_sample;
	logic        o_half_lsb_offset;
	logic [2:0]  o_ain_sel;
	logic [1:0]  o_ref_src;
	logic [11:0] o_dac_code;
	logic [11:0] ext_val  = 12'h000;
	logic [11:0] temp_val = 12'h000;
	logic [11:0] exp_res  = 12'h000;
	logic [7:0]  rd_val;
	logic [3:0]  r_ch;
	logic        r_temp;
	logic        r_fmt;
	int          fail_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          t_wr;
	int          t_rd;

	adcs_sequencer uut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_sar_cmp(i_sar_cmp), .o_rdata(o_rdata),
		.o_power_en(o_power_en), .o_conv_reset(o_conv_reset),
		.o_sample(o_sample), .o_ain_sel(o_ain_sel),
		.o_temp_route(o_temp_route),
		.o_ref_src(o_ref_src), .o_sensor_vsrc(o_sensor_vsrc),
		.o_ref_gain(o_ref_gain),
		.o_half_lsb_offset(o_half_lsb_offset),
		.o_dac_code(o_dac_code), .o_irq(o_irq));

	adcs_analog_model model (.i_clk_sys(i_clk_sys),
		.i_power_en(o_power_en), .i_ain_sel(o_ain_sel),
		.i_temp_route(o_temp_route), .i_dac_code(o_dac_code),
		.i_ext_val(ext_val), .i_temp_val(temp_val), .o_cmp(i_sar_cmp));

	// 10 MHz clock; cycle count on falling edge avoids edge races
	always #50 i_clk_sys = ~i_clk_sys;
	always @(negedge i_clk_sys)
	begin
		cyc++;
		if (cyc >= LIMIT)
		begin
			fail_count++;
			final_report();
		end
	end

	task automatic final_report();
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Value compare for register reads and port levels
	task automatic chk(input logic [11:0] got, exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch %0t %s %h/%h", $time, what, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		t_wr = cyc;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [2:0] a);
		@(posedge i_clk_sys);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		t_rd = cyc;
		@(negedge i_clk_sys);
		rd_val = o_rdata;
	endtask

	task automatic chk_result();
		logic [7:0] hi;
		logic [7:0] lo;
		hi = r_fmt ? {4'h0, exp_res[11:8]} : exp_res[11:4];
		lo = r_fmt ? exp_res[7:0] : {exp_res[3:0], 4'h0};
		reg_rd(ADCS_OFF_RES_HI);
		chk(12'(rd_val), 12'(hi), "res hi");
		reg_rd(ADCS_OFF_RES_LO);
		chk(12'(rd_val), 12'(lo), "res lo");
	endtask

	// One conversion from start pulse to result, polled or by irq
	task automatic convert(input logic irqm, input logic [2:0] sel);
		int          n;
		int          t;
		int          exp_cyc;
		logic [11:0] v;
		logic        tc;
		// Sensor is converted only with select set and channel 1xxx
		tc = r_temp && r_ch[3];
		exp_cyc = ((tc ? 44 : 4) + 12) << sel;
		reg_wr(ADCS_OFF_CTRL_B, {r_fmt, 2'b00, r_temp, 1'b0, sel});
		v = tc ? temp_val : (ext_val ^ {r_ch[2:0], 9'h000});
		reg_wr(ADCS_OFF_CTRL_A, {3'b101, 1'b0, r_ch});
		repeat (2) @(negedge i_clk_sys);
		chk(12'({o_conv_reset, o_sample}), 12'h002, "held");
		reg_wr(ADCS_OFF_CTRL_A, {3'b001, 1'b0, r_ch});
		n = t_wr;
		reg_wr(ADCS_OFF_IRQ, 8'h00);
		if (irqm)
			reg_wr(ADCS_OFF_IRQ, 8'h03);
		reg_rd(ADCS_OFF_CTRL_A);
		chk(12'(rd_val[ADCS_A_BUSY_BIT]), 12'h001, "busy");
		chk_result();
		chk(12'(o_ain_sel), 12'(r_ch[2:0]), "chan");
		chk(12'(o_temp_route), 12'(tc), "temp");
		if (irqm)
		begin
			while (o_irq !== 1'b1 && cyc < n + exp_cyc + 20)
				@(negedge i_clk_sys);
			t = cyc - n;
		end
		else
		begin
			do
				reg_rd(ADCS_OFF_CTRL_A);
			while (rd_val[ADCS_A_BUSY_BIT] !== 1'b0 &&
				cyc < n + exp_cyc + 20);
			t = t_rd - n;
		end
		chk(12'(t >= exp_cyc + 1 && t <= exp_cyc + 7), 12'h001,
			"conv time");
		reg_rd(ADCS_OFF_CTRL_A);
		chk(12'(rd_val[ADCS_A_BUSY_BIT]), 12'h000, "done");
		chk(12'(o_sample), 12'h000, "no sample");
		exp_res = v;
		chk_result();
		reg_rd(ADCS_OFF_IRQ);
		chk(12'(rd_val[ADCS_I_FLAG_BIT]), 12'h001, "flag");
	endtask

	// Main sequence
	initial
	begin
		void'($urandom(32'h720f82f1));
		repeat (6) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		@(negedge i_clk_sys);
		chk(12'(o_conv_reset), 12'h001, "rst conv");
		for (int a = 0; a < 8; a++)
		begin
			reg_rd(3'(a));
			chk(12'(rd_val), (a == 2) ? 12'h004 : 12'h000, "rst val");
		end
		reg_wr(3'h6, 8'hFF);
		reg_rd(3'h6);
		chk(12'(rd_val), 12'h000, "unmapped");
		reg_wr(ADCS_OFF_CTRL_C, 8'h07);
		repeat (2) @(negedge i_clk_sys);
		chk(12'({o_sensor_vsrc, o_ref_gain}), 12'h003, "ref bits");
		reg_wr(ADCS_OFF_CTRL_C, 8'h04);
		reg_wr(ADCS_OFF_CTRL_B, 8'h03);
		reg_wr(ADCS_OFF_CTRL_A, 8'h20);
		repeat (2) @(negedge i_clk_sys);
		chk(12'({o_power_en, o_half_lsb_offset}), 12'h003,
			"power");
		chk(12'(o_conv_reset), 12'h000, "run");
		chk(12'(o_ain_sel), 12'h000, "chan0");
		chk(12'(o_ref_src), 12'(ADCS_REF_SUPPLY), "ref");
		chk(12'({o_sensor_vsrc, o_ref_gain}), 12'h000, "ref bits");
		reg_rd(ADCS_OFF_CTRL_B);
		chk(12'(rd_val), 12'h003, "ctrl b");
		repeat (STARTUP) @(posedge i_clk_sys);
		for (int k = 0; k < 4; k++)
		begin
			reg_wr(ADCS_OFF_IRQ, {5'h00, 1'b1, 2'(k)});
			repeat (2) @(negedge i_clk_sys);
			chk(12'(o_irq), 12'(k == 3), "irq gate");
		end
		for (int i = 0; i < 10; i++)
		begin
			ext_val  <= (i < 2) ? {12{i == 0}} : 12'($urandom);
			temp_val <= 12'($urandom);
			r_temp = (i < 2) ? 1'b0 : 1'($urandom);
			r_ch   = (i < 2) ? 4'h0 : {r_temp, 3'($urandom)};
			r_fmt  = 1'($urandom);
			convert(1'(i), 3'($urandom_range(0, 2)));
		end
		r_ch = 4'h5;
		convert(1'b0, 3'h7);
		reg_wr(ADCS_OFF_CTRL_A, 8'hA3);
		reg_wr(ADCS_OFF_CTRL_A, 8'h23);
		repeat (5) @(posedge i_clk_sys);
		r_ch = 4'h6;
		convert(1'b0, 3'h1);
		reg_wr(ADCS_OFF_IRQ, 8'h00);
		reg_wr(ADCS_OFF_CTRL_A, 8'h81);
		reg_wr(ADCS_OFF_CTRL_A, 8'h01);
		repeat (2) @(negedge i_clk_sys);
		chk(12'({o_power_en, o_half_lsb_offset, o_conv_reset}), 12'h001,
			"off");
		repeat (40) @(posedge i_clk_sys);
		reg_rd(ADCS_OFF_CTRL_A);
		chk(12'(rd_val[ADCS_A_BUSY_BIT]), 12'h000, "off busy");
		reg_rd(ADCS_OFF_IRQ);
		chk(12'(rd_val[ADCS_I_FLAG_BIT]), 12'h000, "off flag");
		chk_result();
		final_report();
	end
endmodule
